//--- temp_sensor_conversion_regs.sv
// Temperature sensor register set, conversion control and alarm output
//
// Overview of operation
// - Convert continuously after reset; each result overwrites the previous value.
// - Continuous mode: 27 ms conversion then 53 ms idle, 80 ms period.
// - A conversion starts at once at power-up; result ready 27 ms later.
// - Power-down bit set stops conversions, aborting one in progress.
// - Power-down clears alarm and fault counter and keeps them clear.
// - Single-conversion bit idles device; each trigger write outside a conversion runs one conversion, one during a conversion is dropped.
// - While powered down the single-conversion bit and trigger writes are ignored.
// - Write-only 8-bit pointer, reset zero, low three bits select register.
// - Select 0 result, 1 configuration, 2 lower, 3 upper, 4 trigger.
// - Result in bits 15:4, two's complement, bits 3:0 read zero.
// - Configuration bits 8,9,10,12:11,13 hold control fields; resets to zero.
// - Fault queue code 0..3 needs 1, 2, 4 or 6 consecutive faults.
// - Level sense 0 makes alarm active low, 1 active high.
// - Behaviour select 0 is comparator, 1 is interrupt behaviour.
// - Lower limit in bits 15:4, resets to 4B00h.
// - Upper limit in bits 15:4, low bits read zero, resets to 5000h.
`timescale 1ns/1ps
module temp_sensor_conversion_regs import temp_sensor_pkg::*; #(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic ptr_wr,
  input wire logic [7:0] ptr_data,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_rd,
  output logic [15:0] rd_data,
  input wire logic [11:0] sample_code,
  output logic conv_busy,
  output logic alert_level
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] pointer_q;
  logic [11:0] result_q;
  logic [11:0] lower_q;
  logic [11:0] upper_q;
  logic power_down_bit_q;
  logic alarm_behaviour_select_q;
  logic alarm_level_sense_q;
  logic [1:0] fault_queue_depth_q;
  logic single_conversion_select_q;
  logic [15:0] config_word;
  logic [15:0] selected_word;
  logic [2:0] register_select;
  logic trigger_pulse;
  logic read_ack;
  logic conv_done;
  logic alarm_active;

  assign register_select = pointer_q[2:0];
  assign trigger_pulse = reg_wr && (register_select == SEL_TRIGGER);
  assign read_ack = reg_rd;

  // ----------------------------------------
  // Pointer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pointer_q <= POINTER_RESET;
    end else if (ce && ptr_wr) begin
      pointer_q <= ptr_data;
    end
  end

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  // Reserved bits are simply not stored, so a careless write cannot disturb them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_down_bit_q <= CONFIG_RESET[CFG_POWER_DOWN];
      alarm_behaviour_select_q <= CONFIG_RESET[CFG_BEHAVIOUR];
      alarm_level_sense_q <= CONFIG_RESET[CFG_LEVEL];
      fault_queue_depth_q <= CONFIG_RESET[CFG_QUEUE_MSB:CFG_QUEUE_LSB];
      single_conversion_select_q <= CONFIG_RESET[CFG_SINGLE];
    end else if (ce && reg_wr && (register_select == SEL_CONFIG)) begin
      power_down_bit_q <= reg_wr_data[CFG_POWER_DOWN];
      alarm_behaviour_select_q <= reg_wr_data[CFG_BEHAVIOUR];
      alarm_level_sense_q <= reg_wr_data[CFG_LEVEL];
      fault_queue_depth_q <= reg_wr_data[CFG_QUEUE_MSB:CFG_QUEUE_LSB];
      single_conversion_select_q <= reg_wr_data[CFG_SINGLE];
    end
  end

  always_comb begin
    config_word = 16'h0000;
    config_word[CFG_POWER_DOWN] = power_down_bit_q;
    config_word[CFG_BEHAVIOUR] = alarm_behaviour_select_q;
    config_word[CFG_LEVEL] = alarm_level_sense_q;
    config_word[CFG_QUEUE_MSB:CFG_QUEUE_LSB] = fault_queue_depth_q;
    config_word[CFG_SINGLE] = single_conversion_select_q;
  end

  // ----------------------------------------
  // Limits
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lower_q <= LOWER_RESET[15:DATA_LSB];
    end else if (ce && reg_wr && (register_select == SEL_LOWER)) begin
      lower_q <= reg_wr_data[15:DATA_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upper_q <= UPPER_RESET[15:DATA_LSB];
    end else if (ce && reg_wr && (register_select == SEL_UPPER)) begin
      upper_q <= reg_wr_data[15:DATA_LSB];
    end
  end

  // ----------------------------------------
  // Result
  // ----------------------------------------
  // Writes aimed at the result register are dropped; it only follows conversions
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= RESULT_RESET[15:DATA_LSB];
    end else if (ce && conv_done) begin
      result_q <= sample_code;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    unique case (register_select)
      SEL_RESULT: selected_word = word_of(result_q);
      SEL_CONFIG: selected_word = config_word;
      SEL_LOWER: selected_word = word_of(lower_q);
      SEL_UPPER: selected_word = word_of(upper_q);
      default: selected_word = 16'h0000;
    endcase
  end

  // The whole word is captured once per read so both bytes belong together
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 16'h0000;
    end else if (ce && reg_rd) begin
      rd_data <= selected_word;
    end
  end

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  conv_sequencer #(
    .CONV_CYCLES(CONV_CYCLES),
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_sequencer (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .power_down(power_down_bit_q),
    .single_sel(single_conversion_select_q),
    .trigger(trigger_pulse),
    .conv_busy(conv_busy),
    .conv_done(conv_done)
  );

  // ----------------------------------------
  // Alarm
  // ----------------------------------------
  alarm_qualifier u_alarm (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .clear(power_down_bit_q),
    .done(conv_done),
    .result(sample_code),
    .lower(lower_q),
    .upper(upper_q),
    .queue_code(fault_queue_depth_q),
    .irq_mode(alarm_behaviour_select_q),
    .read_ack(read_ack),
    .alarm_active(alarm_active)
  );

  // Inactive level at reset is high because the default sense is active low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_level <= 1'b1;
    end else if (ce) begin
      alert_level <= alarm_level_sense_q ? alarm_active : !alarm_active;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  int unsigned busy_run;
  int unsigned idle_run;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_run <= 0;
      idle_run <= 0;
    end else if (ce) begin
      busy_run <= conv_busy ? busy_run + 1 : 0;
      idle_run <= conv_busy ? 0 : idle_run + 1;
    end
  end

  chk_conv_time: assert property (
    @(posedge clk) disable iff (!rst_b)
    conv_done |-> (busy_run == CONV_CYCLES)
  ) else $error("conversion length differs from the conversion time");

  chk_idle_time: assert property (
    @(posedge clk) disable iff (!rst_b)
    // A start out of shutdown has no idle delay, so only starts from the wait state count
    ($rose(conv_busy) && $past(u_sequencer.state_q == SEQ_WAIT) && !$past(single_conversion_select_q))
      |-> (idle_run == IDLE_CYCLES)
  ) else $error("idle delay between conversions is wrong");

  chk_result_update: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && conv_done) |=> (result_q == $past(sample_code))
  ) else $error("finished conversion did not replace the result");

  chk_power_abort: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && power_down_bit_q) |=> !conv_busy
  ) else $error("conversion kept running in power-down");

  chk_alarm_cleared: assert property (
    @(posedge clk) disable iff (!rst_b)
    ($past(ce) && $past(power_down_bit_q)) |-> !alarm_active
  ) else $error("alarm not cleared by power-down");

  chk_single_start: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && trigger_pulse && single_conversion_select_q && !power_down_bit_q && !conv_busy)
      |=> conv_busy
  ) else $error("trigger write did not start a conversion");

  chk_single_return: assert property (
    @(posedge clk) disable iff (!rst_b)
    (conv_done && $past(ce) && $past(single_conversion_select_q)) |-> (u_sequencer.state_q == SEQ_SHUT)
  ) else $error("single conversion did not return to shutdown");

  chk_pointer_config: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && reg_rd && (register_select == SEL_CONFIG)) |=> (rd_data == $past(config_word))
  ) else $error("configuration read returned wrong word");

  chk_result_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && reg_rd && (register_select == SEL_RESULT))
      |=> (rd_data == {$past(result_q), 4'h0})
  ) else $error("result read returned wrong word");

  chk_upper_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && reg_wr && (register_select == SEL_UPPER)) |=> (word_of(upper_q) == {$past(reg_wr_data[15:4]), 4'h0})
  ) else $error("upper limit write not stored");

  chk_read_stable: assert property (
    @(posedge clk) disable iff (!rst_b)
    !(ce && reg_rd) |=> $stable(rd_data)
  ) else $error("read word changed without a read");

  chk_alert_sense: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && !alarm_active && !alarm_level_sense_q) |=> alert_level
  ) else $error("inactive alarm drove the active level");

  chk_alert_active: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && alarm_active && !alarm_level_sense_q) |=> !alert_level
  ) else $error("active alarm did not drive the low level");

endmodule

//--- temp_sensor_pkg.sv
// Shared constants, types and decoders of the temperature sensor sequencer
package temp_sensor_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int CONV_TIME_MS = 27;
  localparam int IDLE_TIME_MS = 53;
  localparam int CONV_CYCLES_DEF = CONV_TIME_MS * CYCLES_PER_MS;
  localparam int IDLE_CYCLES_DEF = IDLE_TIME_MS * CYCLES_PER_MS;
  localparam int CNT_W = 23;
  // ----------------------------------------
  // Register selection and layout
  // ----------------------------------------
  localparam logic [2:0] SEL_RESULT = 3'h0;
  localparam logic [2:0] SEL_CONFIG = 3'h1;
  localparam logic [2:0] SEL_LOWER = 3'h2;
  localparam logic [2:0] SEL_UPPER = 3'h3;
  localparam logic [2:0] SEL_TRIGGER = 3'h4;
  localparam int DATA_LSB = 4;
  localparam int CFG_POWER_DOWN = 8;
  localparam int CFG_BEHAVIOUR = 9;
  localparam int CFG_LEVEL = 10;
  localparam int CFG_QUEUE_LSB = 11;
  localparam int CFG_QUEUE_MSB = 12;
  localparam int CFG_SINGLE = 13;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] LOWER_RESET = 16'h4B00;
  localparam logic [15:0] UPPER_RESET = 16'h5000;

  typedef enum logic [1:0] {
    SEQ_CONVERT = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_SHUT = 2'b11
  } seq_state_type;

  function automatic logic [2:0] faults_needed(input logic [1:0] code);
    unique case (code)
      2'h0: faults_needed = 3'h1;
      2'h1: faults_needed = 3'h2;
      2'h2: faults_needed = 3'h4;
      2'h3: faults_needed = 3'h6;
    endcase
  endfunction

  function automatic logic [15:0] word_of(input logic [11:0] value);
    word_of = {value, 4'h0};
  endfunction
endpackage

//--- conv_sequencer.sv
// Conversion timing sequencer: continuous, shutdown and single-shot operation
`timescale 1ns/1ps
module conv_sequencer import temp_sensor_pkg::*; #(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic power_down,
  input wire logic single_sel,
  input wire logic trigger,
  output logic conv_busy,
  output logic conv_done
);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);
  seq_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q;
  logic conv_end;

  assign conv_end = (state_q == SEQ_CONVERT) && !power_down && (cnt_q == CONV_LAST);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SEQ_CONVERT: begin
        if (power_down) begin
          state_d = SEQ_SHUT;
        end else if (cnt_q == CONV_LAST) begin
          state_d = single_sel ? SEQ_SHUT : SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (!power_down && single_sel && trigger) begin
          state_d = SEQ_CONVERT;
        end else if (power_down || single_sel) begin
          state_d = SEQ_SHUT;
        end else if (cnt_q == IDLE_LAST) begin
          state_d = SEQ_CONVERT;
        end
      end
      SEQ_SHUT: begin
        if (!power_down && (!single_sel || trigger)) begin
          state_d = SEQ_CONVERT;
        end
      end
      default: state_d = SEQ_SHUT;
    endcase
  end

  // Reset lands in convert so the first result follows power-up directly
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SEQ_CONVERT;
      cnt_q <= '0;
      conv_busy <= 1'b1;
      conv_done <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
      conv_busy <= (state_d == SEQ_CONVERT);
      conv_done <= conv_end;
    end
  end
endmodule

//--- alarm_qualifier.sv
// Alarm fault queue with comparator and interrupt behaviour
`timescale 1ns/1ps
module alarm_qualifier import temp_sensor_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clear,
  input wire logic done,
  input wire logic [11:0] result,
  input wire logic [11:0] lower,
  input wire logic [11:0] upper,
  input wire logic [1:0] queue_code,
  input wire logic irq_mode,
  input wire logic read_ack,
  output logic alarm_active
);
  logic cmp_q, irq_q, watch_low_q;
  logic [2:0] fault_cnt_q;
  logic watching_low, fault, qualified;

  assign watching_low = irq_mode ? watch_low_q : cmp_q;
  assign fault = watching_low ? ($signed(result) < $signed(lower)) : ($signed(result) >= $signed(upper));
  assign qualified = done && fault && ((fault_cnt_q + 3'h1) >= faults_needed(queue_code));
  assign alarm_active = irq_mode ? irq_q : cmp_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_q <= 1'b0;
      irq_q <= 1'b0;
      watch_low_q <= 1'b0;
      fault_cnt_q <= 3'h0;
    end else if (ce) begin
      if (clear) begin
        cmp_q <= 1'b0;
        irq_q <= 1'b0;
        watch_low_q <= 1'b0;
        fault_cnt_q <= 3'h0;
      end else begin
        if (done) begin
          fault_cnt_q <= (!fault || qualified) ? 3'h0 : fault_cnt_q + 3'h1;
        end
        if (qualified && !irq_mode) begin
          cmp_q <= !cmp_q;
        end
        if (qualified && irq_mode) begin
          watch_low_q <= !watch_low_q;
        end
        // A crossing in the same cycle as a read still raises the alarm
        if (qualified && irq_mode) begin
          irq_q <= 1'b1;
        end else if (read_ack) begin
          irq_q <= 1'b0;
        end
      end
    end
  end
endmodule

//--- host_model.sv
// Host side register-port master standing in for the serial bus controller
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic ptr_wr,
  output logic [7:0] ptr_data,
  output logic reg_wr,
  output logic [15:0] reg_wr_data,
  output logic reg_rd,
  input wire logic [15:0] rd_data
);
  initial begin
    ptr_wr = 1'b0;
    ptr_data = 8'h00;
    reg_wr = 1'b0;
    reg_wr_data = 16'h0000;
    reg_rd = 1'b0;
  end
  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  // Upper pointer bits carry junk on purpose; released lines show inverted data
  task automatic set_ptr(input logic [2:0] sel);
    @(posedge clk);
    #1;
    ptr_wr = 1'b1;
    ptr_data = {5'h15, sel};
    @(posedge clk);
    #1;
    ptr_wr = 1'b0;
    ptr_data = ~ptr_data;
  endtask

  task automatic write_word(input logic [2:0] sel, input logic [15:0] data);
    set_ptr(sel);
    reg_wr = 1'b1;
    reg_wr_data = (sel == 3'h1) ? (data & 16'h3F00) : data;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wr_data = ~reg_wr_data;
  endtask

  task automatic read_now(output logic [15:0] data);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    data = rd_data;
  endtask

  task automatic read_word(input logic [2:0] sel, output logic [15:0] data);
    set_ptr(sel);
    read_now(data);
  endtask
endmodule

//--- testbench.sv
// Self-checking testbench of the temperature sensor register and conversion block
`timescale 1ns/1ps
module testbench;
  localparam int CONV = 20;
  localparam int IDLE = 30;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic ptr_wr, reg_wr, reg_rd, conv_busy, alert_level;
  logic [7:0] ptr_data;
  logic [15:0] reg_wr_data, rd_data, val;
  logic [11:0] sample_code = 12'h123;
  int miscompares = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  temp_sensor_conversion_regs #(.CONV_CYCLES(CONV), .IDLE_CYCLES(IDLE)) temp_sensor_conversion_regs_inst (
    .clk(clk), .rst_b(rst_b), .ce(ce), .ptr_wr(ptr_wr), .ptr_data(ptr_data), .reg_wr(reg_wr),
    .reg_wr_data(reg_wr_data), .reg_rd(reg_rd), .rd_data(rd_data), .sample_code(sample_code),
    .conv_busy(conv_busy), .alert_level(alert_level));

  host_model host_model_inst (
    .clk(clk), .ptr_wr(ptr_wr), .ptr_data(ptr_data), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data),
    .reg_rd(reg_rd), .rd_data(rd_data));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy !== lvl) begin
      tick(1);
      n++;
      if (n > 200) begin
        miscompares++;
        $display("[FAIL] conv_busy wait expected %b seen %b", lvl, conv_busy);
        give_verdict();
      end
    end
  endtask

  // Alarm settles two cycles after the conversion ends, so look a cycle later
  task automatic end_conv();
    wait_busy(1'b1);
    wait_busy(1'b0);
    tick(3);
  endtask

  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (conv_busy === lvl && n < 300) begin
      tick(1);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      $display("[FAIL] conv_busy run expected below %0d seen %0d", 300, n);
      give_verdict();
    end
  endtask

  task automatic quiet(input int cycles, output int n);
    n = 0;
    repeat (cycles) begin
      tick(1);
      if (conv_busy !== 1'b0) begin
        n++;
      end
    end
  endtask

  task automatic count_alarm(input logic lvl, output int n);
    n = 0;
    do begin
      end_conv();
      n++;
    end while (alert_level !== lvl && n < 8);
    if (alert_level !== lvl) begin
      miscompares++;
      $display("[FAIL] alert_level wait expected %b seen %b", lvl, alert_level);
      give_verdict();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_startup();
    int n;
    run_len(1'b1, n);
    check("first conversion in range", 16'h0001, 16'((n >= CONV - 1) && (n <= CONV)));
    run_len(1'b0, n);
    check("idle length", 16'(IDLE), 16'(n));
    run_len(1'b1, n);
    check("conversion length", 16'(CONV), 16'(n));
    host_model_inst.read_now(val);
    check("result at reset pointer", 16'h1230, val);
    sample_code = 12'hF9C;
    end_conv();
    host_model_inst.read_now(val);
    check("result overwritten", 16'hF9C0, val);
  endtask

  task automatic s_regs();
    logic [15:0] exp [5] = '{16'hF9C0, 16'h0000, 16'h4B00, 16'h5000, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      host_model_inst.read_word(3'(i), val);
      check("reset value", exp[i], val);
    end
    host_model_inst.write_word(3'h2, 16'h1234);
    host_model_inst.write_word(3'h3, 16'h7FFF);
    host_model_inst.write_word(3'h0, 16'hFFFF);
    host_model_inst.write_word(3'h1, 16'h3E00);
    exp = '{16'hF9C0, 16'h3E00, 16'h1230, 16'h7FF0, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      host_model_inst.read_word(3'(i), val);
      check("written value", exp[i], val);
    end
    host_model_inst.write_word(3'h2, 16'h4B00);
    host_model_inst.write_word(3'h3, 16'h5000);
    host_model_inst.write_word(3'h1, 16'h0000);
  endtask

  task automatic s_queue();
    int need [4] = '{1, 2, 4, 6};
    int n;
    for (int q = 0; q < 4; q++) begin
      host_model_inst.write_word(3'h1, {3'h0, 2'(q), 11'h000});
      end_conv();
      sample_code = 12'h510;
      count_alarm(1'b0, n);
      check("faults to assert", 16'(need[q]), 16'(n));
      sample_code = 12'h4A0;
      count_alarm(1'b1, n);
      check("faults to release", 16'(need[q]), 16'(n));
    end
  endtask

  task automatic s_power_down();
    int n;
    host_model_inst.write_word(3'h1, 16'h0000);
    sample_code = 12'h510;
    end_conv();
    end_conv();
    check("alarm active low", 16'h0000, {15'h0, alert_level});
    wait_busy(1'b1);
    host_model_inst.write_word(3'h1, 16'h0100);
    tick(2);
    check("conversion aborted", 16'h0000, {15'h0, conv_busy});
    tick(1);
    check("alarm cleared", 16'h0001, {15'h0, alert_level});
    host_model_inst.write_word(3'h4, 16'h0001);
    host_model_inst.write_word(3'h1, 16'h2100);
    host_model_inst.write_word(3'h4, 16'h0001);
    quiet(150, n);
    check("no conversion powered down", 16'h0000, 16'(n));
    check("alarm stays cleared", 16'h0001, {15'h0, alert_level});
  endtask

  task automatic s_one_shot();
    int n;
    host_model_inst.write_word(3'h1, 16'h2000);
    sample_code = 12'h0A5;
    quiet(100, n);
    check("shutdown idle", 16'h0000, 16'(n));
    host_model_inst.write_word(3'h4, 16'hBEEF);
    wait_busy(1'b1);
    // Frozen cycles must stretch the conversion, so the measured run still equals the full length
    ce = 1'b0;
    tick(5);
    ce = 1'b1;
    run_len(1'b1, n);
    check("single conversion length", 16'(CONV), 16'(n));
    quiet(100, n);
    check("back to shutdown", 16'h0000, 16'(n));
    host_model_inst.read_word(3'h0, val);
    check("single conversion result", 16'h0A50, val);
  endtask

  task automatic s_irq();
    sample_code = 12'h100;
    host_model_inst.write_word(3'h1, 16'h0000);
    end_conv();
    end_conv();
    check("idle level low-active", 16'h0001, {15'h0, alert_level});
    host_model_inst.write_word(3'h1, 16'h0400);
    tick(3);
    check("idle level high-active", 16'h0000, {15'h0, alert_level});
    host_model_inst.write_word(3'h1, 16'h0200);
    sample_code = 12'h510;
    end_conv();
    end_conv();
    check("interrupt latched", 16'h0000, {15'h0, alert_level});
    host_model_inst.read_now(val);
    tick(3);
    check("cleared by read", 16'h0001, {15'h0, alert_level});
    end_conv();
    check("watching lower limit", 16'h0001, {15'h0, alert_level});
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    s_startup();
    s_regs();
    s_queue();
    s_power_down();
    s_one_shot();
    s_irq();
    give_verdict();
  end
endmodule
